// file: cko_regs.vh
`ifndef CKO_REGS_VH
`define CKO_REGS_VH

// ****************************************************************
// Register byte offsets on the APB bus.
// ****************************************************************
`define CKO_OFF_RESET_WORD 8'h00
`define CKO_OFF_CHAN0 8'h10
`define CKO_OFF_CHAN1 8'h14
`define CKO_OFF_CHAN2 8'h18
`define CKO_OFF_CHAN3 8'h1C
`define CKO_OFF_SWING 8'h24
`define CKO_OFF_PRESCALE 8'h2C
`define CKO_OFF_FILTER 8'h34
`define CKO_OFF_GLOBAL 8'h38
`define CKO_OFF_FEEDBACK 8'h3C
`define CKO_OFF_STATUS 8'h40

// ****************************************************************
// Field positions.
// ****************************************************************
`define CKO_SOFT_RESET_BIT 31
`define CKO_PATH_MSB 18
`define CKO_PATH_LSB 17
`define CKO_CHAN_ON_BIT 16
`define CKO_DIV_MSB 15
`define CKO_DIV_LSB 8
`define CKO_DLY_MSB 7
`define CKO_DLY_LSB 4
`define CKO_SWING_BIT 16
`define CKO_PRESCALE_BIT 15
`define CKO_REF_MSB 21
`define CKO_REF_LSB 14
`define CKO_RES_B_MSB 13
`define CKO_RES_B_LSB 11
`define CKO_RES_A_MSB 10
`define CKO_RES_A_LSB 8
`define CKO_CAP_MSB 7
`define CKO_CAP_LSB 4
`define CKO_ALL_ON_BIT 27
`define CKO_SLEEP_BIT 26
`define CKO_LOCK_MSB 23
`define CKO_LOCK_LSB 20
`define CKO_VCO_DIV_MSB 29
`define CKO_VCO_DIV_LSB 26

// ****************************************************************
// Reset values of the stored words.
// ****************************************************************
`define CKO_RST_RESET_WORD 32'h00000000
`define CKO_RST_CHAN 32'h00000100
`define CKO_RST_SWING 32'h00000000
`define CKO_RST_PRESCALE 32'h00000000
`define CKO_RST_FILTER 32'h00028000
`define CKO_RST_GLOBAL 32'h08000A00
`define CKO_RST_FEEDBACK 32'h0802F800

// ****************************************************************
// Path selector codes and added path delays in picoseconds.
// ****************************************************************
`define CKO_PATH_BYPASS 2'h0
`define CKO_PATH_DIVIDED 2'h1
`define CKO_PATH_DELAYED 2'h2
`define CKO_PATH_BOTH 2'h3
`define CKO_PS_DIVIDED 12'h064
`define CKO_PS_DELAYED 12'h190
`define CKO_PS_BOTH 12'h1F4
`define CKO_PS_STEP 8'h96

`endif

// file: cko_channel.v
`include "cko_regs.vh"

// ****************************************************************
// One output channel: decodes its stored word into the effective
// divide ratio, total division, added delay and active state.
// ****************************************************************
module cko_channel (
    input wire [31:0] word,      // Stored channel word.
    input wire gate_ok,          // Global enable, gate pin and awake.
    input wire [3:0] vco_div,    // Shared VCO divider ratio.
    output reg active,           // Channel output is running.
    output reg [8:0] ratio,      // Effective channel divide ratio.
    output reg [11:0] delay_ps,  // Added delay against bypass.
    output reg [12:0] total_div  // VCO ratio times channel ratio.
);

    wire [1:0] path;
    wire [7:0] div_code;
    wire [3:0] dly_code;
    wire [11:0] prog_ps;

    assign path = word[`CKO_PATH_MSB:`CKO_PATH_LSB];
    assign div_code = word[`CKO_DIV_MSB:`CKO_DIV_LSB];
    assign dly_code = word[`CKO_DLY_MSB:`CKO_DLY_LSB];
    // Programmed delay in 150 ps steps, up to 2250 ps.
    assign prog_ps = {8'h00, dly_code} * {4'h0, `CKO_PS_STEP}; // [RULE10]

    // Path decode; a code only counts on a path that uses its block.
    always @*
    begin
        active = word[`CKO_CHAN_ON_BIT] & gate_ok; // [RULE11]
        ratio = 9'h001;
        delay_ps = 12'h000;
        case (path) // [RULE3]
            `CKO_PATH_DIVIDED:
            begin
                ratio = {div_code, 1'b0}; // [RULE5] [RULE6]
                delay_ps = `CKO_PS_DIVIDED; // [RULE4]
            end
            `CKO_PATH_DELAYED:
            begin
                delay_ps = `CKO_PS_DELAYED + prog_ps; // [RULE4] [RULE9]
            end
            `CKO_PATH_BOTH:
            begin
                ratio = {div_code, 1'b0}; // [RULE5] [RULE6]
                delay_ps = `CKO_PS_BOTH + prog_ps; // [RULE4] [RULE9]
            end
            default:
            begin
                ratio = 9'h001;
                delay_ps = 12'h000;
            end
        endcase
        // Channel divider follows the shared VCO divider.
        total_div = {9'h000, vco_div} * {4'h0, ratio}; // [RULE7]
    end

endmodule // cko_channel

// file: cko_config.v
// Functional notes
// [RULE1] Writing one to R0 bit 31 restores all registers, itself included.
// [RULE2] With bit 31 set, other R0 bits are ignored; host rewrites R0.
// [RULE3] Path selector bits 18:17: bypass, divided, delayed, both.
// [RULE4] Divided adds 100 ps, delayed 400 ps, both 500 ps.
// [RULE5] Divider code acts only on divided or divided-and-delayed paths.
// [RULE6] Divide ratio is twice the code; default code 1, zero invalid.
// [RULE7] Channel total division is VCO ratio times channel ratio.
// [RULE8] Host pulses the align pin after programming all dividers.
// [RULE9] Delay code acts only on delayed or divided-and-delayed paths.
// [RULE10] Programmed delay is code times 150 ps, default zero.
// [RULE11] Channel active needs its enable, global enable and gate pin high.
// [RULE12] Four identical channels 0 to 3 with same field positions.
// [RULE13] Swing boost bit 16 of R9 defaults to zero.
// [RULE14] Host sets prescale bit 15 of R11 above 20 MHz with lock detect.
// [RULE15] Global output enable bit 27 of R14 defaults to one.
// [RULE16] Power-down bit 26 of R14 defaults to zero.
// [RULE17] Lock pin selector bits 23:20 of R14 default to zero.
// [RULE18] Reference frequency bits 21:14 of R13 default to 10 MHz.
// [RULE19] R13 filter selects at 7:4, 10:8 and 13:11 default zero.
// [RULE20] Each 32-bit word is applied whole at the end of its write.
//
// The APB register port and the register offsets were chosen for this implementation.

`include "cko_regs.vh"

module cko_config (
    input wire pclk,                       // Bus clock, 100 MHz.
    input wire presetn,                    // Asynchronous reset, low.
    input wire psel,                       // APB select.
    input wire penable,                    // APB access phase.
    input wire pwrite,                     // APB write when high.
    input wire [7:0] paddr,                // APB byte address.
    input wire [31:0] pwdata,              // APB write data.
    output reg [31:0] prdata,              // APB read data.
    output reg pready,                     // APB ready.
    output reg pslverr,                    // APB error, unmapped address.
    input wire output_gate_pin,            // Output gate pin, from outside.
    output reg [3:0] ch_active,            // Per channel running state.
    output reg [35:0] ch_ratio,            // Four 9-bit channel ratios.
    output reg [47:0] ch_delay_ps,         // Four 12-bit added delays.
    output reg [51:0] ch_total_div,        // Four 13-bit total divisions.
    output reg all_outputs_on,             // Global output enable.
    output reg chip_sleep,                 // Device power-down.
    output reg [3:0] lock_pin_mode,        // Lock pin function select.
    output reg swing_boost,                // Raised output swing.
    output reg lock_detect_prescale,       // Lock detect divide by four.
    output reg [7:0] ref_input_mhz,        // Reference input in MHz.
    output reg [3:0] filter_cap_select,    // Loop filter capacitor select.
    output reg [2:0] filter_res_a_select,  // Loop filter resistor A.
    output reg [2:0] filter_res_b_select,  // Loop filter resistor B.
    output reg [3:0] vco_divide            // Shared VCO divider ratio.
);

    // ****************************************************************
    // Stored configuration words.
    // ****************************************************************
    reg [31:0] reset_word_q;
    reg [31:0] ch_word_q [0:3];
    reg [31:0] swing_word_q;
    reg [31:0] prescale_word_q;
    reg [31:0] filter_word_q;
    reg [31:0] global_word_q;
    reg [31:0] feedback_word_q;

    // ****************************************************************
    // Bus decode and gate pin synchroniser.
    // ****************************************************************
    reg gate_meta_q;
    reg gate_sync_q;
    reg [31:0] rdata_d;
    reg hit_d;
    wire wr_commit;
    wire soft_reset;
    wire gate_ok;
    wire [3:0] chan_active_w;
    wire [35:0] chan_ratio_w;
    wire [47:0] chan_delay_w;
    wire [51:0] chan_total_w;
    integer i;

    // A write lands only at the access edge where ready is seen high,
    // so a word is never applied half-written.
    assign wr_commit = psel & penable & pready & pwrite & ~pslverr; // [RULE20]

    // Soft reset wins over the rest of the reset word in the same write.
    assign soft_reset = wr_commit & (paddr == `CKO_OFF_RESET_WORD) &
                        pwdata[`CKO_SOFT_RESET_BIT]; // [RULE1] [RULE2]

    // The gate pin is asynchronous; two flops keep metastability out.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gate_meta_q <= 1'b0;
            gate_sync_q <= 1'b0;
        end
        else
        begin
            gate_meta_q <= output_gate_pin;
            gate_sync_q <= gate_meta_q;
        end
    end

    // Power-down stops every output whatever the other bits say.
    assign gate_ok = global_word_q[`CKO_ALL_ON_BIT] & gate_sync_q &
                     ~global_word_q[`CKO_SLEEP_BIT]; // [RULE11] [RULE15]

    // ****************************************************************
    // Channel decoders, one per output.
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : gen_chan
            cko_channel u_chan (
                .word(ch_word_q[g]),
                .gate_ok(gate_ok),
                .vco_div(feedback_word_q[`CKO_VCO_DIV_MSB:`CKO_VCO_DIV_LSB]),
                .active(chan_active_w[g]),
                .ratio(chan_ratio_w[g*9 +: 9]),
                .delay_ps(chan_delay_w[g*12 +: 12]),
                .total_div(chan_total_w[g*13 +: 13])
            ); // [RULE12]
        end
    endgenerate

    // ****************************************************************
    // Read multiplexer.
    // ****************************************************************

    // Address decode; unmapped addresses read zero and flag an error.
    always @*
    begin
        rdata_d = 32'h00000000;
        hit_d = 1'b1;
        case (paddr)
            `CKO_OFF_RESET_WORD: rdata_d = reset_word_q;
            `CKO_OFF_CHAN0: rdata_d = ch_word_q[0];
            `CKO_OFF_CHAN1: rdata_d = ch_word_q[1];
            `CKO_OFF_CHAN2: rdata_d = ch_word_q[2];
            `CKO_OFF_CHAN3: rdata_d = ch_word_q[3];
            `CKO_OFF_SWING: rdata_d = swing_word_q;
            `CKO_OFF_PRESCALE: rdata_d = prescale_word_q;
            `CKO_OFF_FILTER: rdata_d = filter_word_q;
            `CKO_OFF_GLOBAL: rdata_d = global_word_q;
            `CKO_OFF_FEEDBACK: rdata_d = feedback_word_q;
            `CKO_OFF_STATUS: rdata_d = {26'h0000000, gate_sync_q,
                                         gate_ok, chan_active_w};
            default: hit_d = 1'b0;
        endcase
    end

    // ****************************************************************
    // APB answer: ready is raised in every access phase, no waits.
    // ****************************************************************

    // Read data and error are captured in the setup cycle so that they
    // come from flops and stand for the whole access phase.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit_d;
            if (psel & ~penable & ~pwrite)
            begin
                prdata <= rdata_d;
            end
            else if (!psel)
            begin
                prdata <= 32'h00000000;
            end
        end
    end

    // ****************************************************************
    // Configuration storage.
    // ****************************************************************

    // Status is read-only; writes to it are accepted and dropped.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            reset_word_q <= `CKO_RST_RESET_WORD;
            for (i = 0; i < 4; i = i + 1)
            begin
                ch_word_q[i] <= `CKO_RST_CHAN; // [RULE6] [RULE10] [RULE11]
            end
            swing_word_q <= `CKO_RST_SWING; // [RULE13]
            prescale_word_q <= `CKO_RST_PRESCALE;
            filter_word_q <= `CKO_RST_FILTER; // [RULE18] [RULE19]
            global_word_q <= `CKO_RST_GLOBAL; // [RULE15] [RULE16] [RULE17]
            feedback_word_q <= `CKO_RST_FEEDBACK;
        end
        else if (soft_reset)
        begin
            // Every word back to its default, the reset bit cleared too.
            reset_word_q <= `CKO_RST_RESET_WORD; // [RULE1] [RULE2]
            for (i = 0; i < 4; i = i + 1)
            begin
                ch_word_q[i] <= `CKO_RST_CHAN; // [RULE1]
            end
            swing_word_q <= `CKO_RST_SWING; // [RULE1]
            prescale_word_q <= `CKO_RST_PRESCALE; // [RULE1]
            filter_word_q <= `CKO_RST_FILTER; // [RULE1]
            global_word_q <= `CKO_RST_GLOBAL; // [RULE1]
            feedback_word_q <= `CKO_RST_FEEDBACK; // [RULE1]
        end
        else if (wr_commit)
        begin
            case (paddr)
                `CKO_OFF_RESET_WORD: reset_word_q <= pwdata; // [RULE20]
                `CKO_OFF_CHAN0: ch_word_q[0] <= pwdata; // [RULE20]
                `CKO_OFF_CHAN1: ch_word_q[1] <= pwdata; // [RULE20]
                `CKO_OFF_CHAN2: ch_word_q[2] <= pwdata; // [RULE20]
                `CKO_OFF_CHAN3: ch_word_q[3] <= pwdata; // [RULE20]
                `CKO_OFF_SWING: swing_word_q <= pwdata; // [RULE20]
                `CKO_OFF_PRESCALE: prescale_word_q <= pwdata; // [RULE20]
                `CKO_OFF_FILTER: filter_word_q <= pwdata; // [RULE20]
                `CKO_OFF_GLOBAL: global_word_q <= pwdata; // [RULE20]
                `CKO_OFF_FEEDBACK: feedback_word_q <= pwdata; // [RULE20]
                default: reset_word_q <= reset_word_q;
            endcase
        end
    end

    // ****************************************************************
    // Registered outputs.
    // ****************************************************************

    // Decoded values are registered so every output leaves a flop; they
    // trail the stored words by one clock.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ch_active <= 4'h0;
            ch_ratio <= {4{9'h001}};
            ch_delay_ps <= 48'h000000000000;
            ch_total_div <= {4{13'h0002}};
            all_outputs_on <= 1'b1;
            chip_sleep <= 1'b0;
            lock_pin_mode <= 4'h0;
            swing_boost <= 1'b0;
            lock_detect_prescale <= 1'b0;
            ref_input_mhz <= 8'h0A;
            filter_cap_select <= 4'h0;
            filter_res_a_select <= 3'h0;
            filter_res_b_select <= 3'h0;
            vco_divide <= 4'h2;
        end
        else
        begin
            ch_active <= chan_active_w; // [RULE11]
            ch_ratio <= chan_ratio_w; // [RULE6]
            ch_delay_ps <= chan_delay_w; // [RULE4]
            ch_total_div <= chan_total_w; // [RULE7]
            all_outputs_on <= global_word_q[`CKO_ALL_ON_BIT]; // [RULE15]
            chip_sleep <= global_word_q[`CKO_SLEEP_BIT]; // [RULE16]
            lock_pin_mode <=
                global_word_q[`CKO_LOCK_MSB:`CKO_LOCK_LSB]; // [RULE17]
            swing_boost <= swing_word_q[`CKO_SWING_BIT]; // [RULE13]
            lock_detect_prescale <= prescale_word_q[`CKO_PRESCALE_BIT];
            ref_input_mhz <=
                filter_word_q[`CKO_REF_MSB:`CKO_REF_LSB]; // [RULE18]
            filter_cap_select <=
                filter_word_q[`CKO_CAP_MSB:`CKO_CAP_LSB]; // [RULE19]
            filter_res_a_select <=
                filter_word_q[`CKO_RES_A_MSB:`CKO_RES_A_LSB]; // [RULE19]
            filter_res_b_select <=
                filter_word_q[`CKO_RES_B_MSB:`CKO_RES_B_LSB]; // [RULE19]
            vco_divide <=
                feedback_word_q[`CKO_VCO_DIV_MSB:`CKO_VCO_DIV_LSB];
        end
    end

endmodule // cko_config

// file: cko_config_asserts.sv
// ****************************************************************
// Port-level checks on the configuration block.
// ****************************************************************
module cko_config_chk (
    input wire logic pclk, // Bus clock.
    input wire logic presetn, // Reset, active low.
    input wire logic psel, // Select.
    input wire logic penable, // Access phase.
    input wire logic pwrite, // Write when high.
    input wire logic [7:0] paddr, // Byte address.
    input wire logic [31:0] pwdata, // Write data.
    input wire logic pready, // Ready.
    input wire logic pslverr, // Error.
    input wire logic output_gate_pin, // Gate pin.
    input wire logic [3:0] ch_active, // Running channels.
    input wire logic [35:0] ch_ratio, // Channel ratios.
    input wire logic [51:0] ch_total_div, // Total divisions.
    input wire logic all_outputs_on, // Global enable.
    input wire logic chip_sleep, // Power-down.
    input wire logic [7:0] ref_input_mhz, // Reference in MHz.
    input wire logic [3:0] vco_divide // Shared ratio.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic mapped;
    logic rat_ok;
    logic tot_ok;
    logic [8:0] r;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Decoded address map; any other address must answer with an error.
    assign mapped = paddr inside {8'h00, 8'h10, 8'h14, 8'h18, 8'h1C,
        8'h24, 8'h2C, 8'h34, 8'h38, 8'h3C, 8'h40};

    // One loop covers all four channels, cheaper than four assertions.
    always_comb
    begin
        rat_ok = 1'b1;
        tot_ok = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            r = ch_ratio[9 * i +: 9];
            if (r[0] && r != 9'h001)
                rat_ok = 1'b0;
            if (ch_total_div[13 * i +: 13] != 13'(vco_divide) * 13'(r))
                tot_ok = 1'b0;
        end
    end

    property p_rdy_next;
        psel && !penable |=> pready;
    endproperty
    a_rdy_next: assert property (p_rdy_next)
        else $error("ready missing after setup");
    property p_rdy_only;
        pready |-> psel && penable;
    endproperty
    a_rdy_only: assert property (p_rdy_only)
        else $error("ready outside access phase");
    property p_err_map;
        pready |-> pslverr == !mapped;
    endproperty
    a_err_map: assert property (p_err_map)
        else $error("error flag wrong for address");
    property p_gate_off;
        !output_gate_pin [*4] |-> ch_active == 4'h0;
    endproperty
    a_gate_off: assert property (p_gate_off)
        else $error("channel runs with gate low");
    property p_glob_off;
        (!all_outputs_on || chip_sleep) [*2] |-> ch_active == 4'h0;
    endproperty
    a_glob_off: assert property (p_glob_off)
        else $error("channel runs while globally off");
    property p_ratio;
        $changed(ch_ratio) |-> rat_ok;
    endproperty
    a_ratio: assert property (p_ratio)
        else $error("odd channel ratio");
    property p_total;
        $stable(vco_divide) |-> tot_ok;
    endproperty
    a_total: assert property (p_total)
        else $error("total division not a product");
    property p_soft;
        pready && pwrite && paddr == 8'h00 && pwdata[31] |-> ##2
            (all_outputs_on && !chip_sleep && ref_input_mhz == 8'h0A &&
            vco_divide == 4'h2 && ch_active == 4'h0);
    endproperty
    a_soft: assert property (p_soft)
        else $error("soft reset did not restore defaults");
endmodule // cko_config_chk

bind cko_config cko_config_chk u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .output_gate_pin,
    .ch_active, .ch_ratio, .ch_total_div, .all_outputs_on, .chip_sleep,
    .ref_input_mhz, .vco_divide);

// file: cko_host.sv
// ****************************************************************
// Host controller model: writes and reads configuration words.
// ****************************************************************
module cko_host (
    input wire logic pclk, // Bus clock.
    output logic psel, // Select.
    output logic penable, // Access phase.
    output logic pwrite, // Write when high.
    output logic [7:0] paddr, // Byte address.
    output logic [31:0] pwdata, // Write data.
    input wire logic [31:0] prdata, // Read data.
    input wire logic pready, // Ready.
    input wire logic pslverr // Error.
);
    timeunit 1ns;
    timeprecision 1ps;
    int hangs = 0;

    // Idle bus at time zero.
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // One transfer; the align pulse after divider writes is issued by
    // the board, as this block has no pin for it.
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            hangs++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines show inverted values so stale data cannot pass.
        paddr <= ~a;
        pwdata <= ~wd;
    endtask
endmodule // cko_host

// file: clock_output_config_tb.sv
// ****************************************************************
// Self-checking bench for the configuration block.
// ****************************************************************
module clock_output_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic output_gate_pin = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0] paddr, ref_input_mhz;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] ch_active, lock_pin_mode, filter_cap_select, vco_divide;
    logic [35:0] ch_ratio;
    logic [47:0] ch_delay_ps;
    logic [51:0] ch_total_div;
    logic all_outputs_on, chip_sleep, swing_boost, lock_detect_prescale;
    logic [2:0] filter_res_a_select, filter_res_b_select;
    logic [7:0] addr_t [10] = '{8'h00, 8'h10, 8'h14, 8'h18, 8'h1C,
        8'h24, 8'h2C, 8'h34, 8'h38, 8'h3C};
    logic [31:0] dflt_t [10] = '{32'h0, 32'h100, 32'h100, 32'h100,
        32'h100, 32'h0, 32'h0, 32'h28000, 32'h08000A00, 32'h0802F800};
    int num_errors = 0;
    int checked = 0;

    cko_config dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .output_gate_pin, .ch_active,
        .ch_ratio, .ch_delay_ps, .ch_total_div, .all_outputs_on,
        .chip_sleep, .lock_pin_mode, .swing_boost, .lock_detect_prescale,
        .ref_input_mhz, .filter_cap_select, .filter_res_a_select,
        .filter_res_b_select, .vco_divide);
    cko_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr);

    // Free-running 100 MHz clock.
    always #5 pclk = ~pclk;

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task summarize;
        num_errors += host.hangs;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rdat, rerr);
        if (host.hangs != 0)
            summarize;
    endtask

    task rd(input logic [7:0] a);
        host.xfer(1'b0, a, 32'h0, rdat, rerr);
        if (host.hangs != 0)
            summarize;
    endtask

    // A hung run counts as a mismatch and still reaches the verdict.
    initial
    begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        summarize;
    end

    // Main sequence.
    initial
    begin
        int p, n;
        logic [31:0] w;
        logic [7:0] c;
        logic [3:0] d;
        logic [8:0] r;
        logic [11:0] ps;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (n = 0; n < 10; n++)
        begin
            rd(addr_t[n]);
            chk(rdat, dflt_t[n]);
        end
        chk({all_outputs_on, chip_sleep, lock_pin_mode, swing_boost,
            lock_detect_prescale, ref_input_mhz}, 16'h800A);
        chk({filter_cap_select, filter_res_a_select}, 0);
        chk({ch_active, filter_res_b_select}, 0);
        $display("test defaults done");
        for (n = 0; n < 4; n++)
            for (p = 0; p < 4; p++)
            begin
                c = (n == 3) ? 8'hFF : 8'(n + 2);
                d = (n == 3) ? 4'hF : 4'(n + 5);
                w = {13'h0, 2'(p), 1'(p != 2), c, d, 4'h0};
                wr(8'h10 + 8'(4 * n), w);
                repeat (2) @(posedge pclk);
                r = p[0] ? {c, 1'b0} : 9'h001;
                ps = (p == 0) ? 12'h0 : (p == 1) ? 12'd100 :
                    12'(d * 150 + ((p == 2) ? 400 : 500));
                chk(ch_ratio[9 * n +: 9], r);
                chk(ch_delay_ps[12 * n +: 12], ps);
                chk(ch_total_div[13 * n +: 13], {r, 1'b0});
                chk(ch_active[n], p != 2);
                rd(8'h10 + 8'(4 * n));
                chk(rdat, w);
            end
        $display("test channels done");
        output_gate_pin <= 1'b0;
        repeat (4) @(posedge pclk);
        chk(ch_active, 4'h0);
        output_gate_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        chk(ch_active, 4'hF);
        for (n = 0; n < 2; n++)
        begin
            wr(8'h38, n ? 32'h0C000A00 : 32'h00B00A00);
            repeat (2) @(posedge pclk);
            chk({ch_active, chip_sleep, all_outputs_on, lock_pin_mode},
                n ? 10'h030 : 10'h00B);
        end
        wr(8'h38, 32'h08000A00);
        wr(8'h3C, 32'h0C02F800);
        repeat (3) @(posedge pclk);
        chk({ch_active, vco_divide, ch_total_div[12:0]},
            {4'hF, 4'h3, 13'd12});
        $display("test gating done");
        wr(8'h34, 32'h00322AB0);
        wr(8'h24, 32'h00010000);
        wr(8'h2C, 32'h00008000);
        repeat (2) @(posedge pclk);
        chk({ref_input_mhz, filter_res_b_select, filter_res_a_select,
            filter_cap_select, swing_boost, lock_detect_prescale},
            {8'hC8, 3'h5, 3'h2, 4'hB, 2'h3});
        $display("test fields done");
        rd(8'h08);
        chk({rerr, rdat[30:0]}, 32'h80000000);
        wr(8'h08, 32'hFFFFFFFF);
        chk(rerr, 1'b1);
        $display("test unmapped done");
        wr(8'h00, 32'h80000001);
        repeat (2) @(posedge pclk);
        chk({ref_input_mhz, vco_divide, swing_boost, ch_active},
            {8'h0A, 4'h2, 1'b0, 4'h0});
        rd(8'h00);
        chk(rdat, 32'h0);
        rd(8'h10);
        chk(rdat, 32'h100);
        wr(8'h00, 32'h00000001);
        rd(8'h00);
        chk(rdat, 32'h1);
        wr(8'h40, 32'hFFFFFFFF);
        chk(rerr, 1'b0);
        rd(8'h40);
        chk({rerr, rdat[30:0]}, 32'h00000030);
        $display("test soft reset done");
        summarize;
    end
endmodule // clock_output_config_tb
